/* logic/pvr_consts.svh */
// Constants for the PHY vendor register bank: offsets, fields, reset values and timing.
// How it works
// - Immediate registers 00-3Fh also answer at the same extended register address.
// - Vendor registers live at 30h-3Fh and use plain immediate read and write.
// - Two-bit trim: 00 nominal, 01 reserved, 10 plus 7.4 percent, 11 plus 3.7 percent.
// - Trim register bits 4:0 and bit 7 always read zero.
// - Headset mode is on only when key field equals 1010; upper nibble reads zero.
// - ID measure register reads at 36h-38h; write 36h, set 37h, clear 38h.
// - Result code: 000 0R, 001 75R, 010 100K, 011 200K, 100 440K, 101 float, 111 error.
// - Start bit launches a measurement and clears itself when the measurement ends.
// - Done flag asserts by itself when a 282 us measurement finishes.
// - Reading result at 36h-38h clears done; carkit status mirror read does not.
// - Enable ORed with carkit enable raises alt_int when done asserts.
// - IO and power register reads at 39h-3Bh; write 39h, set 3Ah, clear 3Bh.
// - Swap bit exchanges the two data lines in USB and UART modes.
// - UART regulator level, reset 01, applies on UART entry with transmit drive on.
// - Charger pull-up bits connect pull-ups; UART mode forces both on.
// - USB regulator level, reset 00, applies in synchronous, serial and low power mode.
`ifndef PVR_CONSTS_SVH
`define PVR_CONSTS_SVH

`define PVR_ADDR_TRIM 6'h31
`define PVR_ADDR_HSET 6'h33
`define PVR_ADDR_IDM_WR 6'h36
`define PVR_ADDR_IDM_SET 6'h37
`define PVR_ADDR_IDM_CLR 6'h38
`define PVR_ADDR_IOP_WR 6'h39
`define PVR_ADDR_IOP_SET 6'h3a
`define PVR_ADDR_IOP_CLR 6'h3b

`define PVR_TRIM_LSB 5
`define PVR_TRIM_MSB 6
`define PVR_HSET_KEY 4'ha
`define PVR_IDM_DONE_BIT 3
`define PVR_IDM_GO_BIT 4
`define PVR_IDM_RSVD_BIT 5
`define PVR_IDM_IRQEN_BIT 6
`define PVR_IDM_WMASK 8'h70
`define PVR_IOP_WMASK 8'hfe
`define PVR_IOP_RESET 8'h04

`define PVR_CLK_MHZ 250
`define PVR_MEAS_US 282
`define PVR_MEAS_CYC (`PVR_MEAS_US * `PVR_CLK_MHZ)

`endif

/* logic/pvr_pkg.sv */
// Types shared by the PHY vendor register bank.
package pvr_pkg;
    typedef enum logic [1:0] {PVR_PHY_SYNC, PVR_PHY_SERIAL, PVR_PHY_LOWPWR, PVR_PHY_UART} pvr_mode_e;
    typedef enum logic {PVR_MEAS_IDLE, PVR_MEAS_RUN} pvr_meas_e;
    typedef logic [7:0] pvr_byte_t;
endpackage : pvr_pkg

/* logic/pvr_vendor_bank.sv */
// PHY vendor register bank on the ULPI register read and write path.
`timescale 1ns/100ps
`include "pvr_consts.svh"

module pvr_vendor_bank
    import pvr_pkg::*;
#(
    parameter int MEAS_CYCLES = `PVR_MEAS_CYC
) (
    input wire logic clk, // ULPI clock, 250 MHz
    input wire logic rstn, // Synchronous reset, active low
    input wire logic regWrite, // One-cycle register write strobe
    input wire logic regRead, // One-cycle register read strobe
    input wire logic regExtended, // Access came through an extended address
    input wire logic [7:0] regAddr, // Immediate or extended register address
    input wire logic [7:0] regWdata, // Write data
    input wire logic carkitIrqEn, // ID interrupt enable from the carkit set
    input wire logic [2:0] idMeasResult, // Result code from the ID converter
    input wire logic [1:0] phyMode, // Current PHY operating mode
    input wire logic uartTxDriveEn, // UART transmit drive enable
    output logic [7:0] regRdata, // Read data, valid the cycle after regRead
    output logic regRvalid, // Read data valid pulse
    output logic idMeasStart, // Pulse that launches the ID converter
    output logic altInt, // alt_int for the RXCMD byte
    output logic [1:0] txAmpTrim, // Transmit amplitude trim
    output logic headsetModeOn, // Headset audio mode enabled
    output logic linePairSwap, // Data line swap
    output logic plusLineChargerPullup, // Pull-up on plus data line
    output logic minusLineChargerPullup, // Pull-up on minus data line
    output logic [1:0] ldoLevel, // Regulator level now in force
    output logic [2:0] idResistorCode, // Latest result, also for carkit mirror
    output logic idMeasureDone // Done flag, also for carkit mirror
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------

    // Extended addresses below 40h alias the immediate map.
    function automatic logic [5:0] mapAddr(input logic ext, input logic [7:0] a);
        logic [5:0] r;
        r = 6'h00;
        if (!ext || a[7:6] == 2'h0) begin
            r = a[5:0];
        end
        return r;
    endfunction : mapAddr

    logic [5:0] addr;
    logic hit;
    assign addr = mapAddr(regExtended, regAddr);
    assign hit = !regExtended || regAddr[7:6] == 2'h0;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    logic [1:0] trim_q;
    logic [3:0] key_q;
    pvr_byte_t idm_q;
    pvr_byte_t iop_q;
    logic [2:0] code_q;
    logic done_q;
    pvr_meas_e meas_q;
    logic [$clog2(MEAS_CYCLES + 1) - 1:0] cnt_q;
    logic measEnd;
    logic doneClr;

    assign measEnd = meas_q == PVR_MEAS_RUN && cnt_q == '0;
    // Reading the mirror in the carkit status block never reaches this port.
    assign doneClr = regRead && hit && addr >= `PVR_ADDR_IDM_WR && addr <= `PVR_ADDR_IDM_CLR;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            trim_q <= 2'h0;
        end else if (regWrite && hit && addr == `PVR_ADDR_TRIM) begin
            trim_q <= regWdata[`PVR_TRIM_MSB:`PVR_TRIM_LSB];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            key_q <= 4'h0;
        end else if (regWrite && hit && addr == `PVR_ADDR_HSET) begin
            key_q <= regWdata[3:0];
        end
    end

    // Only go, reserved bit five and the enable are writable; done and code are status.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            idm_q <= 8'h00;
        end else begin
            if (regWrite && hit && addr == `PVR_ADDR_IDM_WR) begin
                idm_q <= regWdata & `PVR_IDM_WMASK;
            end else if (regWrite && hit && addr == `PVR_ADDR_IDM_SET) begin
                idm_q <= idm_q | (regWdata & `PVR_IDM_WMASK);
            end else if (regWrite && hit && addr == `PVR_ADDR_IDM_CLR) begin
                idm_q <= idm_q & ~(regWdata & `PVR_IDM_WMASK);
            end
            if (measEnd) begin
                idm_q[`PVR_IDM_GO_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            iop_q <= `PVR_IOP_RESET;
        end else if (regWrite && hit && addr == `PVR_ADDR_IOP_WR) begin
            iop_q <= regWdata & `PVR_IOP_WMASK;
        end else if (regWrite && hit && addr == `PVR_ADDR_IOP_SET) begin
            iop_q <= iop_q | (regWdata & `PVR_IOP_WMASK);
        end else if (regWrite && hit && addr == `PVR_ADDR_IOP_CLR) begin
            iop_q <= iop_q & ~(regWdata & `PVR_IOP_WMASK);
        end
    end

    // ------------------------------------------------------------
    // ID measurement sequencer
    // ------------------------------------------------------------

    // A start raised during a run is absorbed: the run in progress clears it on completion.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            meas_q <= PVR_MEAS_IDLE;
            cnt_q <= '0;
            idMeasStart <= 1'b0;
        end else begin
            idMeasStart <= 1'b0;
            case (meas_q)
                PVR_MEAS_IDLE: begin
                    if (idm_q[`PVR_IDM_GO_BIT]) begin
                        meas_q <= PVR_MEAS_RUN;
                        cnt_q <= ($bits(cnt_q))'(MEAS_CYCLES - 2);
                        idMeasStart <= 1'b1;
                    end
                end
                PVR_MEAS_RUN: begin
                    if (cnt_q == '0) begin
                        meas_q <= PVR_MEAS_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default: meas_q <= PVR_MEAS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            code_q <= 3'h0;
        end else if (measEnd) begin
            code_q <= idMeasResult;
        end
    end

    // Completion wins over a clearing read in the same cycle.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            done_q <= 1'b0;
        end else if (measEnd) begin
            done_q <= 1'b1;
        end else if (doneClr) begin
            done_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            altInt <= 1'b0;
        end else begin
            // Pulse on the edge that raises the done output, so the link sees both together.
            altInt <= done_q && !idMeasureDone && (idm_q[`PVR_IDM_IRQEN_BIT] || carkitIrqEn);
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------

    always_ff @(posedge clk) begin
        if (!rstn) begin
            regRdata <= 8'h00;
            regRvalid <= 1'b0;
        end else begin
            regRvalid <= regRead;
            if (regRead) begin
                if (!hit) begin
                    regRdata <= 8'h00;
                end else if (addr == `PVR_ADDR_TRIM) begin
                    regRdata <= {1'b0, trim_q, 5'h00};
                end else if (addr == `PVR_ADDR_HSET) begin
                    regRdata <= {4'h0, key_q};
                end else if (addr >= `PVR_ADDR_IDM_WR && addr <= `PVR_ADDR_IDM_CLR) begin
                    regRdata <= {1'b0, idm_q[6:4], done_q, code_q};
                end else if (addr >= `PVR_ADDR_IOP_WR && addr <= `PVR_ADDR_IOP_CLR) begin
                    regRdata <= iop_q;
                end else begin
                    regRdata <= 8'h00;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Pin and regulator controls
    // ------------------------------------------------------------

    always_ff @(posedge clk) begin
        if (!rstn) begin
            txAmpTrim <= 2'h0;
            headsetModeOn <= 1'b0;
            linePairSwap <= 1'b0;
            plusLineChargerPullup <= 1'b0;
            minusLineChargerPullup <= 1'b0;
            ldoLevel <= 2'h0;
            idResistorCode <= 3'h0;
            idMeasureDone <= 1'b0;
        end else begin
            txAmpTrim <= trim_q;
            headsetModeOn <= key_q == `PVR_HSET_KEY;
            linePairSwap <= iop_q[1];
            plusLineChargerPullup <= iop_q[4] || phyMode == PVR_PHY_UART;
            minusLineChargerPullup <= iop_q[5] || phyMode == PVR_PHY_UART;
            if (phyMode == PVR_PHY_UART) begin
                if (uartTxDriveEn) begin
                    ldoLevel <= iop_q[3:2];
                end
            end else begin
                ldoLevel <= iop_q[7:6];
            end
            idResistorCode <= code_q;
            idMeasureDone <= done_q;
        end
    end

endmodule : pvr_vendor_bank

/* bench/pvr_vendor_bank_props.sv */
// Checker for the PHY vendor register bank ports.
`timescale 1ns/100ps
module pvr_vendor_bank_props #(
    parameter int MEAS_CYCLES = 20
) (
    input wire logic clk, // Clock
    input wire logic rstn, // Reset, active low
    input wire logic regRead, // Read strobe
    input wire logic regExtended, // Extended access
    input wire logic [7:0] regAddr, // Address
    input wire logic [7:0] regRdata, // Read data
    input wire logic regRvalid, // Read valid
    input wire logic idMeasStart, // Start pulse
    input wire logic altInt, // Interrupt pulse
    input wire logic idMeasureDone // Done flag
);
    // ----------------
    // Measurement timing
    // ----------------
    // A counter keeps the long measurement window out of the property unrolling.
    logic [31:0] sinceGo_q;
    always_ff @(posedge clk)
        if (!rstn || idMeasStart) sinceGo_q <= '0;
        else if (sinceGo_q < 32'hffffff) sinceGo_q <= sinceGo_q + 32'h1;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_read_answer: assert property (regRead |=> regRvalid) else $error("read not answered");
    chk_valid_cause: assert property (regRvalid |-> $past(regRead)) else $error("stray read valid");
    chk_unmapped_zero: assert property (regRead && regExtended && regAddr >= 8'h40 |=> regRdata == 8'h00)
        else $error("unmapped read not zero");
    chk_trim_ro: assert property (regRead && regAddr == 8'h31 |=> (regRdata & 8'h9f) == 8'h00)
        else $error("trim fixed bits set");
    chk_hset_upper: assert property (regRead && regAddr == 8'h33 |=> regRdata[7:4] == 4'h0)
        else $error("headset upper bits set");
    chk_iop_zero: assert property (regRead && regAddr inside {[8'h39:8'h3b]} |=> !regRdata[0])
        else $error("io bit zero set");
    chk_irq_done: assert property (altInt |-> idMeasureDone && !$past(idMeasureDone))
        else $error("irq without new done");
    chk_done_window: assert property ($rose(idMeasureDone) |->
        sinceGo_q + 2 >= MEAS_CYCLES && sinceGo_q <= MEAS_CYCLES + 1)
        else $error("done at wrong time");
    chk_done_clears: assert property (regRead && regAddr == 8'h36 && idMeasureDone |-> ##2 !idMeasureDone)
        else $error("done not cleared by read");
    cover property (altInt);
    cover property (regRead && regExtended);
    cover property ($fell(idMeasureDone));
endmodule : pvr_vendor_bank_props
bind pvr_vendor_bank pvr_vendor_bank_props #(.MEAS_CYCLES(MEAS_CYCLES)) pvr_vendor_bank_props_i (.*);

/* bench/pvr_id_conv_model.sv */
// Behavioural ID resistor converter feeding the register bank.
`timescale 1ns/100ps
module pvr_id_conv_model (
    input wire logic clk, // Clock
    input wire logic idMeasStart, // Start pulse from the bank
    input wire logic [2:0] nextCode, // Code the bench wants measured
    output logic [2:0] idMeasResult // Result, held until the next start
);
    always_ff @(posedge clk)
        if (idMeasStart) idMeasResult <= nextCode;
endmodule : pvr_id_conv_model

/* bench/testbench.sv */
// Self-checking bench for the PHY vendor register bank.
`timescale 1ns/100ps
module testbench;
    logic clk = 1'b0, rstn = 1'b0, regWrite = 1'b0, regRead = 1'b0, regExtended = 1'b0, ie, irq;
    logic carkitIrqEn = 1'b0, uartTxDriveEn = 1'b0, regRvalid, idMeasStart, altInt, headsetModeOn;
    logic linePairSwap, plusLineChargerPullup, minusLineChargerPullup, idMeasureDone;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, d, iop;
    logic [1:0] phyMode = 2'd0, txAmpTrim, ldoLevel;
    logic [2:0] idMeasResult, idResistorCode, nextCode = 3'd0;
    logic [2:0] codes [7] = '{3'd0, 3'd1, 3'd2, 3'd3, 3'd4, 3'd5, 3'd7};
    int errorCnt = 0, checksDone = 0, seed = 93999, i, n;
    always #2 clk = ~clk;
    pvr_vendor_bank #(.MEAS_CYCLES(20)) pvr_vendor_bank_i (.*);
    pvr_id_conv_model pvr_id_conv_model_i (.*);
    // ----------------
    // Bus tasks
    // ----------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errorCnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        @(posedge clk);
        #1;
        check(regRdata, exp);
    endtask : rd
    task automatic endSim;
        $display("checks %0d mismatches %0d", checksDone, errorCnt);
        if (errorCnt == 0 && checksDone > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : endSim
    // ----------------
    // Tests
    // ----------------
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        rd(8'h31, 8'h00);
        rd(8'h33, 8'h00);
        rd(8'h36, 8'h00);
        rd(8'h39, 8'h04);
        check({6'h0, ldoLevel}, 8'h00);
        $display("test reset done");
        for (i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            wr(8'h31, {d[7], i[1:0], d[4:0]});
            rd(8'h31, {1'b0, i[1:0], 5'h00});
            check({6'h0, txAmpTrim}, 8'(i));
            if (i < 2) d[3:0] = 4'ha;
            wr(8'h33, d);
            rd(8'h33, {4'h0, d[3:0]});
            check({7'h0, headsetModeOn}, {7'h0, d[3:0] == 4'ha});
        end
        $display("test trim and headset done");
        iop = 8'h04;
        for (i = 0; i < 6; i++) begin
            d = 8'($random(seed));
            wr(8'h39 + 8'(i % 3), d);
            iop = (i % 3 == 0) ? d & 8'hfe : (i % 3 == 1) ? iop | (d & 8'hfe) : iop & ~d;
            rd(8'h3b - 8'(i % 3), iop);
            check({2'h0, linePairSwap, plusLineChargerPullup, minusLineChargerPullup, 1'b0, ldoLevel},
                {2'h0, iop[1], iop[4], iop[5], 1'b0, iop[7:6]});
        end
        @(posedge clk);
        regExtended <= 1'b1;
        rd(8'h3a, iop);
        rd(8'h45, 8'h00);
        @(posedge clk);
        regExtended <= 1'b0;
        rd(8'h32, 8'h00);
        $display("test io register done");
        wr(8'h3b, 8'h30);
        iop = iop & 8'hcf;
        @(posedge clk);
        phyMode <= 2'd3;
        uartTxDriveEn <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check({3'h0, plusLineChargerPullup, minusLineChargerPullup, 1'b0, ldoLevel}, {3'h0, 2'h3, 1'b0, iop[3:2]});
        @(posedge clk);
        phyMode <= 2'd1;
        repeat (4) @(posedge clk);
        #1;
        check({6'h0, ldoLevel}, {6'h0, iop[7:6]});
        $display("test modes done");
        for (i = 0; i < 7; i++) begin
            nextCode = codes[i];
            ie = i[1];
            @(posedge clk);
            carkitIrqEn <= i[0];
            wr(8'h37, {1'b0, ie, 6'h10});
            irq = 1'b0;
            n = 0;
            while (idMeasureDone !== 1'b1 && n < 200) begin
                @(posedge clk);
                #1;
                irq = irq | altInt;
                n++;
            end
            check({7'h0, irq}, {7'h0, i[0] | ie});
            rd(8'h36, {1'b0, ie, 3'h1, codes[i]});
            check({4'h0, idMeasureDone, idResistorCode}, {5'h0, codes[i]});
            wr(8'h38, 8'h40);
        end
        $display("test id measurement done");
        endSim();
    end
    // The tests need about three hundred cycles; some sixty times that marks a hang.
    initial begin
        repeat (20000) @(posedge clk);
        errorCnt++;
        endSim();
    end
endmodule : testbench
